// file: src/pwm_stage_pkg.sv
package pwm_stage_pkg;

    localparam int CNT_W = 16;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_OCFG   = 8'h04;
    localparam logic [7:0] ADDR_BDT    = 8'h08;
    localparam logic [7:0] ADDR_IDLE   = 8'h0C;
    localparam logic [7:0] ADDR_CMP1   = 8'h10;
    localparam logic [7:0] ADDR_CMP2   = 8'h14;
    localparam logic [7:0] ADDR_RELOAD = 8'h18;
    localparam logic [7:0] ADDR_MODE   = 8'h1C;
    localparam logic [7:0] ADDR_COUNT  = 8'h20;

    // counter_control fields
    localparam int CTRL_DIR    = 4;
    localparam int CTRL_CMS_LO = 5;
    localparam int CTRL_CKD_LO = 8;

    // output_enable_polarity_config fields, four bits per channel
    localparam int OCFG_EN     = 0;
    localparam int OCFG_POL    = 1;
    localparam int OCFG_NEN    = 2;
    localparam int OCFG_NPOL   = 3;
    localparam int OCFG_STRIDE = 4;
    localparam int OCFG_W      = 8;

    // break_deadtime_config fields
    localparam int BDT_DTG_LO  = 0;
    localparam int BDT_LOCK_LO = 8;
    localparam int BDT_MOE     = 15;
    localparam logic [15:0] BDT_MASK  = 16'h83FF;
    localparam logic [15:0] BDT_RESET = 16'h8000;

    // Idle level bits: ch1 main, ch1 comp, ch2 main
    localparam int IDLE_CH1   = 0;
    localparam int IDLE_CH1N  = 1;
    localparam int IDLE_CH2   = 2;
    localparam int MODE_W     = 4;

    localparam logic [CNT_W-1:0] RELOAD_RESET = 16'hFFFF;

    // Dead time clock divider codes
    localparam logic [1:0] CKD_DIV1 = 2'h0;
    localparam logic [1:0] CKD_DIV2 = 2'h1;
    localparam logic [1:0] CKD_DIV4 = 2'h2;

    // Compare mode codes
    localparam logic [3:0] MODE_FROZEN  = 4'h0;
    localparam logic [3:0] MODE_SET     = 4'h1;
    localparam logic [3:0] MODE_CLEAR   = 4'h2;
    localparam logic [3:0] MODE_TOGGLE  = 4'h3;
    localparam logic [3:0] MODE_FORCE_L = 4'h4;
    localparam logic [3:0] MODE_FORCE_H = 4'h5;
    localparam logic [3:0] MODE_PWM1    = 4'h6;
    localparam logic [3:0] MODE_PWM2    = 4'h7;

    // Dead time length in dead time clock ticks
    function automatic logic [9:0] dt_length(input logic [7:0] code);
        logic [9:0] len;
        len = {2'h0, code};
        if (code[7:6] == 2'h2)
            len = {2'h0, 1'h1, code[5:0], 1'h0};
        else if (code[7:5] == 3'h6)
            len = {1'h0, 1'h1, code[4:0], 3'h0};
        else if (code[7:5] == 3'h7)
            len = {1'h1, code[4:0], 4'h0};
        return len;
    endfunction

endpackage

// file: src/deadtime_gen.sv
`timescale 1ns/1ps
module deadtime_gen (
    // Clock, reset, enable
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    // Settings
    input  wire logic [7:0] dt_code,
    input  wire logic [1:0] clk_div,
    // Reference in, shaped pair out
    input  wire logic       ref_in,
    output logic            main_dt,
    output logic            comp_dt
);

    logic [1:0] div_q;
    logic [1:0] div_d;
    logic [1:0] div_last;
    logic       dts_tick;
    logic       ref_q;
    logic       ref_change;
    logic [9:0] cnt_q;
    logic [9:0] cnt_d;
    logic       cnt_zero;

    // Unsupported divider code runs undivided
    assign div_last   = (clk_div == pwm_stage_pkg::CKD_DIV2) ? 2'h1 :
                        (clk_div == pwm_stage_pkg::CKD_DIV4) ? 2'h3 : 2'h0;
    assign dts_tick   = (div_q == div_last);
    assign ref_change = (ref_in != ref_q);
    assign cnt_zero   = (cnt_q == 10'h000);
    // Prescaler restarts on every edge so each dead time is whole ticks
    assign div_d      = (ref_change || dts_tick) ? 2'h0 : div_q + 2'h1;
    assign cnt_d      = ref_change ? pwm_stage_pkg::dt_length(dt_code) :
                        (!cnt_zero && dts_tick) ? cnt_q - 10'h001 : cnt_q;

    // Only rising edges are delayed; falling edges pass at once
    assign main_dt = ref_q && cnt_zero;
    assign comp_dt = !ref_q && cnt_zero;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            div_q <= 2'h0;
            ref_q <= 1'h0;
            cnt_q <= 10'h000;
        end
        else if (clk_en)
        begin
            div_q <= div_d;
            ref_q <= ref_in;
            cnt_q <= cnt_d;
        end
    end

    no_overlap_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !(main_dt && comp_dt))
        else $error("Main and complementary outputs overlap");

    dt_load_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && ref_change) |=> cnt_q == pwm_stage_pkg::dt_length($past(dt_code)))
        else $error("Dead time length loaded wrongly");

    dts_div_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (clk_en && !cnt_zero && !ref_change && div_q == 2'h0
         && clk_div == pwm_stage_pkg::CKD_DIV2) |=> cnt_q == $past(cnt_q))
        else $error("Dead time counted faster than the divided clock");

endmodule

// file: src/pwm_out_stage.sv
`timescale 1ns/1ps
module pwm_out_stage #(
    parameter int CHAN_COUNT = 2
) (
    // Clock, reset, enable
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Sync pin
    input  wire logic        sync_in,
    // Outputs
    output logic             ch1_main_out,
    output logic             ch1_comp_out,
    output logic             ch2_main_out,
    // Event pulses
    output logic             ch1_compare_flag,
    output logic             ch2_compare_flag,
    output logic             update_flag
);

    localparam int W = pwm_stage_pkg::CNT_W;
    localparam int MW = pwm_stage_pkg::MODE_W;
    localparam logic [7:0] DT_PROBE = 8'h02;

    // Software-visible registers
    logic [9:0]  ctrl_q;
    logic [7:0]  ocfg_q;
    logic [15:0] bdt_q;
    logic [2:0]  idle_q;
    logic [W-1:0] cmp_pre_q [2];
    logic [W-1:0] reload_pre_q;
    logic [2*MW-1:0] mode_pre_q;

    // Active copies, loaded on update or sync
    logic [W-1:0] cmp_act_q [2];
    logic [W-1:0] reload_act_q;
    logic [2*MW-1:0] mode_act_q;

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic [1:0]  ref_q;
    logic [1:0]  ref_d;
    logic [1:0]  match;
    logic        sync_s1_q;
    logic        sync_s2_q;
    logic        sync_s3_q;

    logic        sync_rise;
    logic        at_top;
    logic        update_ev;
    logic        load_cfg;

    // Register decode
    logic        wr_ctrl;
    logic        wr_ocfg;
    logic        wr_bdt;
    logic        wr_idle;
    logic        wr_cmp1;
    logic        wr_cmp2;
    logic        wr_reload;
    logic        wr_mode;
    logic [31:0] rd_mux;

    assign wr_ctrl   = reg_wr && (reg_addr == pwm_stage_pkg::ADDR_CTRL);
    assign wr_ocfg   = reg_wr && (reg_addr == pwm_stage_pkg::ADDR_OCFG);
    assign wr_bdt    = reg_wr && (reg_addr == pwm_stage_pkg::ADDR_BDT);
    assign wr_idle   = reg_wr && (reg_addr == pwm_stage_pkg::ADDR_IDLE);
    assign wr_cmp1   = reg_wr && (reg_addr == pwm_stage_pkg::ADDR_CMP1);
    assign wr_cmp2   = reg_wr && (reg_addr == pwm_stage_pkg::ADDR_CMP2);
    assign wr_reload = reg_wr && (reg_addr == pwm_stage_pkg::ADDR_RELOAD);
    assign wr_mode   = reg_wr && (reg_addr == pwm_stage_pkg::ADDR_MODE);

    // Unmapped addresses read as zero
    assign rd_mux =
        (reg_addr == pwm_stage_pkg::ADDR_CTRL)   ? {22'h00_0000, ctrl_q} :
        (reg_addr == pwm_stage_pkg::ADDR_OCFG)   ? {24'h00_0000, ocfg_q} :
        (reg_addr == pwm_stage_pkg::ADDR_BDT)    ? {16'h0000, bdt_q} :
        (reg_addr == pwm_stage_pkg::ADDR_IDLE)   ? {29'h0000_0000, idle_q} :
        (reg_addr == pwm_stage_pkg::ADDR_CMP1)   ? {16'h0000, cmp_pre_q[0]} :
        (reg_addr == pwm_stage_pkg::ADDR_CMP2)   ? {16'h0000, cmp_pre_q[1]} :
        (reg_addr == pwm_stage_pkg::ADDR_RELOAD) ? {16'h0000, reload_pre_q} :
        (reg_addr == pwm_stage_pkg::ADDR_MODE)   ? {24'h00_0000, mode_pre_q} :
        (reg_addr == pwm_stage_pkg::ADDR_COUNT)  ? {16'h0000, cnt_q} : 32'h0000_0000;

    // Field views
    logic [1:0] deadtime_clock_divider;
    logic [7:0] dtg;
    logic       main_output_enable_flag;
    logic       en1;
    logic       pol1;
    logic       nen1;
    logic       npol1;
    logic       en2;
    logic       pol2;
    logic [1:0] ch1_sel;
    logic       ch2_present;

    assign deadtime_clock_divider   = ctrl_q[pwm_stage_pkg::CTRL_CKD_LO +: 2];
    assign dtg   = bdt_q[pwm_stage_pkg::BDT_DTG_LO +: 8];
    assign main_output_enable_flag   = bdt_q[pwm_stage_pkg::BDT_MOE];
    assign en1   = ocfg_q[pwm_stage_pkg::OCFG_EN];
    assign pol1  = ocfg_q[pwm_stage_pkg::OCFG_POL];
    assign nen1  = ocfg_q[pwm_stage_pkg::OCFG_NEN];
    assign npol1 = ocfg_q[pwm_stage_pkg::OCFG_NPOL];
    assign en2   = ocfg_q[pwm_stage_pkg::OCFG_STRIDE + pwm_stage_pkg::OCFG_EN];
    assign pol2  = ocfg_q[pwm_stage_pkg::OCFG_STRIDE + pwm_stage_pkg::OCFG_POL];
    assign ch1_sel = {nen1, en1};
    assign ch2_present = (CHAN_COUNT > 1);

    // Sync pin crossing and edge detect
    assign sync_rise = sync_s2_q && !sync_s3_q;

    // Up-counter only; the direction and centre fields are stored but unused
    assign at_top    = (cnt_q == reload_act_q);
    assign update_ev = at_top && !sync_rise;
    assign load_cfg  = update_ev || sync_rise;
    assign cnt_d     = (sync_rise || at_top) ? '0 : cnt_q + 16'h0001;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ctrl_q       <= '0;
            ocfg_q       <= '0;
            bdt_q        <= pwm_stage_pkg::BDT_RESET;
            idle_q       <= '0;
            cmp_pre_q[0] <= '0;
            cmp_pre_q[1] <= '0;
            reload_pre_q <= pwm_stage_pkg::RELOAD_RESET;
            mode_pre_q   <= '0;
        end
        else if (clk_en)
        begin
            if (wr_ctrl)
                ctrl_q <= reg_wdata[9:0];
            if (wr_ocfg)
                ocfg_q <= reg_wdata[pwm_stage_pkg::OCFG_W-1:0];
            if (wr_bdt)
                bdt_q <= reg_wdata[15:0] & pwm_stage_pkg::BDT_MASK;
            if (wr_idle)
                idle_q <= reg_wdata[2:0];
            if (wr_cmp1)
                cmp_pre_q[0] <= reg_wdata[W-1:0];
            if (wr_cmp2)
                cmp_pre_q[1] <= reg_wdata[W-1:0];
            if (wr_reload)
                reload_pre_q <= reg_wdata[W-1:0];
            if (wr_mode)
                mode_pre_q <= reg_wdata[2*MW-1:0];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            reg_rdata <= '0;
        else if (clk_en)
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sync_s1_q <= 1'h0;
            sync_s2_q <= 1'h0;
            sync_s3_q <= 1'h0;
        end
        else if (clk_en)
        begin
            sync_s1_q <= sync_in;
            sync_s2_q <= sync_s1_q;
            sync_s3_q <= sync_s2_q;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            cnt_q        <= '0;
            cmp_act_q[0] <= '0;
            cmp_act_q[1] <= '0;
            reload_act_q <= pwm_stage_pkg::RELOAD_RESET;
            mode_act_q   <= '0;
        end
        else if (clk_en)
        begin
            cnt_q <= cnt_d;
            if (load_cfg)
            begin
                cmp_act_q    <= cmp_pre_q;
                reload_act_q <= reload_pre_q;
                mode_act_q   <= mode_pre_q;
            end
        end
    end

    // Reference per channel
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_ref
            logic [MW-1:0] mode;
            logic          below;
            assign mode      = mode_act_q[gi*MW +: MW];
            assign match[gi] = (cnt_q == cmp_act_q[gi]);
            assign below     = (cnt_q < cmp_act_q[gi]);
            // Combined and asymmetric codes are not modelled; the reference holds
            assign ref_d[gi] =
                (mode == pwm_stage_pkg::MODE_SET)     ? (match[gi] | ref_q[gi]) :
                (mode == pwm_stage_pkg::MODE_CLEAR)   ? (!match[gi] & ref_q[gi]) :
                (mode == pwm_stage_pkg::MODE_TOGGLE)  ? (match[gi] ^ ref_q[gi]) :
                (mode == pwm_stage_pkg::MODE_FORCE_L) ? 1'h0 :
                (mode == pwm_stage_pkg::MODE_FORCE_H) ? 1'h1 :
                (mode == pwm_stage_pkg::MODE_PWM1)    ? below :
                (mode == pwm_stage_pkg::MODE_PWM2)    ? !below : ref_q[gi];
        end
    endgenerate

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            ref_q <= '0;
        else if (clk_en)
            ref_q <= ref_d;
    end

    // Dead time shaping on channel 1
    logic dt_main;
    logic dt_comp;

    deadtime_gen u_deadtime (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .clk_en  (clk_en),
        .dt_code (dtg),
        .clk_div (deadtime_clock_divider),
        .ref_in  (ref_q[0]),
        .main_dt (dt_main),
        .comp_dt (dt_comp)
    );

    // Output selection; main output enable flag gates every output
    logic main1_on;
    logic comp1_on;
    logic main1_sig;
    logic comp1_sig;
    logic ch1_main_d;
    logic ch1_comp_d;
    logic ch2_main_d;

    assign main1_on  = main_output_enable_flag && en1;
    assign comp1_on  = main_output_enable_flag && nen1;
    assign main1_sig = (ch1_sel == 2'h3) ? dt_main : ref_q[0];
    assign comp1_sig = (ch1_sel == 2'h3) ? dt_comp : ref_q[0];
    assign ch1_main_d = main1_on ? (main1_sig ^ pol1)
                                 : idle_q[pwm_stage_pkg::IDLE_CH1];
    assign ch1_comp_d = comp1_on ? (comp1_sig ^ npol1)
                                 : idle_q[pwm_stage_pkg::IDLE_CH1N];
    // Channel 2 enable bit low means the output follows its reference
    assign ch2_main_d = !ch2_present ? 1'h0 :
                        (main_output_enable_flag && !en2) ? (ref_q[1] ^ pol2)
                                      : idle_q[pwm_stage_pkg::IDLE_CH2];

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ch1_main_out     <= 1'h0;
            ch1_comp_out     <= 1'h0;
            ch2_main_out     <= 1'h0;
            ch1_compare_flag <= 1'h0;
            ch2_compare_flag <= 1'h0;
            update_flag      <= 1'h0;
        end
        else if (clk_en)
        begin
            ch1_main_out     <= ch1_main_d;
            ch1_comp_out     <= ch1_comp_d;
            ch2_main_out     <= ch2_main_d;
            ch1_compare_flag <= match[0];
            ch2_compare_flag <= match[1] && ch2_present;
            update_flag      <= update_ev;
        end
        else
        begin
            // Pulses must not stretch while the clock enable is low
            ch1_compare_flag <= 1'h0;
            ch2_compare_flag <= 1'h0;
            update_flag      <= 1'h0;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence dt_setup;
        clk_en && ch1_sel == 2'h3 && main_output_enable_flag && !pol1 && deadtime_clock_divider == pwm_stage_pkg::CKD_DIV1
        && dtg == DT_PROBE && ref_q[0];
    endsequence

    sequence ref1_rise;
        $rose(ref_q[0]) ##0 dt_setup;
    endsequence

    cnt_wrap_a: assert property (
        (clk_en && at_top && !sync_rise) |=> cnt_q == '0 && update_flag)
        else $error("Counter did not wrap at reload");

    cnt_step_a: assert property (
        (clk_en && !at_top && !sync_rise) |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("Counter did not step up by one");

    sync_clear_a: assert property (
        (clk_en && sync_rise) |=> cnt_q == '0 && cmp_act_q[0] == $past(cmp_pre_q[0]))
        else $error("Sync edge did not clear and reload");

    cmp_flag_a: assert property (
        (clk_en && match[0]) |=> ch1_compare_flag ##1 (ch1_compare_flag == $past(match[0])))
        else $error("Compare flag not a match pulse");

    dead_time_a: assert property (
        (ref1_rise ##1 dt_setup [*4]) |-> ch1_main_out && !$past(ch1_main_out))
        else $error("Dead time before main rising edge is wrong");

    both_idle_a: assert property (
        (clk_en && ch1_sel == 2'h0) |=> ch1_main_out == $past(idle_q[pwm_stage_pkg::IDLE_CH1])
                                        && ch1_comp_out == $past(idle_q[pwm_stage_pkg::IDLE_CH1N]))
        else $error("Disabled channel 1 outputs not at idle level");

    main_pol_a: assert property (
        (clk_en && ch1_sel == 2'h1 && main_output_enable_flag) |=> ch1_main_out == $past(ref_q[0] ^ pol1))
        else $error("Main output polarity wrong");

    cfg_now_a: assert property (
        (clk_en && wr_ocfg) ##1 (clk_en && main_output_enable_flag) |=> ch2_main_out == (ch2_present &&
            ($past(reg_wdata[pwm_stage_pkg::OCFG_STRIDE + pwm_stage_pkg::OCFG_EN], 2) ?
             $past(idle_q[pwm_stage_pkg::IDLE_CH2]) : $past(ref_q[1]) ^
             $past(reg_wdata[pwm_stage_pkg::OCFG_STRIDE + pwm_stage_pkg::OCFG_POL], 2))))
        else $error("Output config write did not act at once");

endmodule

// file: verif/gate_driver_model.sv
`timescale 1ns/1ps
module gate_driver_model (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Gate commands, active high
    input  wire logic        high_gate,
    input  wire logic        low_gate,
    // Cycles with both switches on
    output logic      [15:0] overlap_q
);
    // Both switches on at once shorts the rail, so every such cycle is counted
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            overlap_q <= 16'h0000;
        else if (high_gate && low_gate)
            overlap_q <= overlap_q + 16'h0001;
    end
endmodule

// file: verif/complementary_output_stage_deadtime_tb_top.sv
`timescale 1ns/1ps
module complementary_output_stage_deadtime_tb_top;
    logic        mclk;
    logic        rst_n;
    logic        clk_en;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [31:0] reg_rdata;
    logic        sync_in;
    logic        ch1_main_out;
    logic        ch1_comp_out;
    logic        ch2_main_out;
    logic        ch1_compare_flag;
    logic        ch2_compare_flag;
    logic        update_flag;
    logic [15:0] overlap_q;
    logic [15:0] ov0;
    logic [31:0] rd;
    logic [7:0]  ocfg;
    logic [7:0]  code;
    logic [2:0]  idle;
    logic [7:0]  nu;
    logic [7:0]  nc1;
    logic [7:0]  nc2;
    logic        em;
    logic        ec;
    logic        e2;
    int          mismatches;
    int          checks_done;
    int          seed;
    int          r;
    int          k;
    int          exp_q[$];

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    pwm_out_stage #(.CHAN_COUNT(2)) dut_u (
        .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sync_in(sync_in), .ch1_main_out(ch1_main_out), .ch1_comp_out(ch1_comp_out),
        .ch2_main_out(ch2_main_out), .ch1_compare_flag(ch1_compare_flag),
        .ch2_compare_flag(ch2_compare_flag), .update_flag(update_flag)
    );

    gate_driver_model drv_u (
        .mclk(mclk), .rst_n(rst_n), .high_gate(ch1_main_out), .low_gate(ch1_comp_out),
        .overlap_q(overlap_q)
    );

    task automatic give_verdict();
        if (mismatches == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        checks_done++;
        if (seen !== expv)
        begin
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
            mismatches++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // Sync is held over three edges so the synchroniser sees it; timing starts when the outgoing output falls
    task automatic dt_edge(input bit rise_main, output int kk);
        int t;
        int tf;
        tf = -1;
        kk = -1;
        for (t = 0; t < 6000 && (kk < 0 || t < 4); t++)
        begin
            @(posedge mclk);
            sync_in <= (t < 3);
            #1;
            if (tf < 0 && (rise_main ? ch1_comp_out : ch1_main_out) === 1'b0)
                tf = t;
            if (kk < 0 && tf >= 0 && (rise_main ? ch1_main_out : ch1_comp_out) === 1'b1)
                kk = t - tf;
        end
        if (kk < 0)
        begin
            mismatches++;
            give_verdict();
        end
    endtask

    function automatic int exp_dt(input logic [7:0] c, input int div);
        int n;
        if (!c[7])
            n = int'(c);
        else if (!c[6])
            n = (64 + int'(c[5:0])) * 2;
        else if (!c[5])
            n = (32 + int'(c[4:0])) * 8;
        else
            n = (32 + int'(c[4:0])) * 16;
        return n << div;
    endfunction

    initial
    begin
        seed = 32'hd329_6eab;
        mismatches = 0;
        checks_done = 0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        sync_in = 1'b0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        rd_reg(pwm_stage_pkg::ADDR_BDT, rd);
        chk(rd, 32'h0000_8000);
        rd_reg(pwm_stage_pkg::ADDR_RELOAD, rd);
        chk(rd, 32'h0000_ffff);
        rd_reg(8'h40, rd);
        chk(rd, 32'h0000_0000);
        wr(pwm_stage_pkg::ADDR_BDT, 32'hffff_ffff);
        rd_reg(pwm_stage_pkg::ADDR_BDT, rd);
        chk(rd, 32'h0000_83ff);
        wr(pwm_stage_pkg::ADDR_BDT, 32'h0000_8000);
        wr(pwm_stage_pkg::ADDR_CTRL, 32'h0000_0000);
        wr(pwm_stage_pkg::ADDR_OCFG, 32'h0000_00a5);
        rd_reg(pwm_stage_pkg::ADDR_OCFG, rd);
        chk(rd, 32'h0000_00a5);
        dt_edge(1'b0, k);
        // Counter was cleared two edges before the read strobe is sampled
        rd_reg(pwm_stage_pkg::ADDR_COUNT, rd);
        chk(rd, 32'h0000_0001);
        r = int'(rd);
        rd_reg(pwm_stage_pkg::ADDR_COUNT, rd);
        chk(rd, 32'(r + 2));
        // Period of ten counts: forty cycles hold four one-cycle pulses of each kind
        wr(pwm_stage_pkg::ADDR_RELOAD, 32'h0000_0009);
        wr(pwm_stage_pkg::ADDR_CMP1, 32'h0000_0004);
        wr(pwm_stage_pkg::ADDR_CMP2, 32'h0000_0007);
        wr(pwm_stage_pkg::ADDR_MODE, 32'h0000_0066);
        dt_edge(1'b0, k);
        repeat (12) @(posedge mclk);
        nu = 8'h00;
        nc1 = 8'h00;
        nc2 = 8'h00;
        repeat (40)
        begin
            @(posedge mclk);
            #1;
            nu = nu + {7'h00, update_flag};
            nc1 = nc1 + {7'h00, ch1_compare_flag};
            nc2 = nc2 + {7'h00, ch2_compare_flag};
        end
        chk({24'h0, nu}, 32'h0000_0004);
        chk({24'h0, nc1}, 32'h0000_0004);
        chk({24'h0, nc2}, 32'h0000_0004);
        wr(pwm_stage_pkg::ADDR_MODE, 32'h0000_0055);
        dt_edge(1'b1, k);
        repeat (12) @(posedge mclk);
        for (int i = 0; i < 16; i++)
        begin
            r = $random(seed);
            ocfg = {r[7:4], 4'(i)};
            idle = r[10:8];
            wr(pwm_stage_pkg::ADDR_IDLE, {29'h0, idle});
            wr(pwm_stage_pkg::ADDR_OCFG, {24'h0, ocfg});
            repeat (6) @(posedge mclk);
            #1;
            em = ocfg[0] ? ~ocfg[1] : idle[0];
            ec = ocfg[2] ? (~ocfg[0] ^ ocfg[3]) : idle[1];
            e2 = ocfg[4] ? idle[2] : ~ocfg[5];
            chk({31'h0, ch1_main_out}, {31'h0, em});
            chk({31'h0, ch1_comp_out}, {31'h0, ec});
            chk({31'h0, ch2_main_out}, {31'h0, e2});
        end
        wr(pwm_stage_pkg::ADDR_OCFG, 32'h0000_0005);
        repeat (8) @(posedge mclk);
        ov0 = overlap_q;
        for (int i = 0; i < 7; i++)
        begin
            r = $random(seed);
            code = (i % 4 == 0) ? {1'b0, r[6:0]} : (i % 4 == 1) ? {2'b10, r[5:0]} :
                   (i % 4 == 2) ? {3'b110, r[4:0]} : {3'b111, r[4:0]};
            // Last pass uses the short length that the dead time assertion watches
            if (i == 6)
                code = 8'h02;
            exp_q.push_back(exp_dt(code, i % 3));
            exp_q.push_back(exp_dt(code, i % 3));
            wr(pwm_stage_pkg::ADDR_CTRL, 32'(i % 3) << 8);
            wr(pwm_stage_pkg::ADDR_BDT, {16'h0, 8'h80, code});
            wr(pwm_stage_pkg::ADDR_MODE, 32'h0000_0044);
            dt_edge(1'b0, k);
            chk(32'(k), 32'(exp_q.pop_front()));
            wr(pwm_stage_pkg::ADDR_MODE, 32'h0000_0055);
            dt_edge(1'b1, k);
            chk(32'(k), 32'(exp_q.pop_front()));
        end
        chk({16'h0, overlap_q - ov0}, 32'h0000_0000);
        give_verdict();
    end
endmodule
